// file: flash_lock_access_guard.sv
// Purpose: guards every firmware read, write and erase of program flash
// Assumes: core holds REQ one cycle per access; flash array is external
// Notes: a refused access raises FLASH_ERR_RST instead of reaching flash
`timescale 1ns/1ns
module flash_lock_access_guard (
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic SFR_WE,
  input wire logic [7:0] SFR_ADDR,
  input wire logic [7:0] SFR_WDATA,
  output logic [7:0] SFR_RDATA,
  input wire logic REQ,
  input wire flash_guard_pkg::flash_req_t REQ_BUS,
  input wire logic [7:0] LOCK_BYTE,
  output logic FL_READ,
  output logic FL_WRITE,
  output logic FL_ERASE,
  output logic [flash_guard_pkg::ADDR_W-1:0] FL_ADDR,
  output logic [7:0] FL_WDATA,
  output logic FLASH_ERR_RST,
  output logic [7:0] PSC_STATE
);
  localparam int AW = flash_guard_pkg::ADDR_W;
  localparam int PW = flash_guard_pkg::PAGE_W;

  logic [7:0] psc_q;
  logic we_en;
  logic ee_en;
  flash_guard_pkg::access_ctx_t ctx;
  flash_guard_pkg::op_t eff_op;
  logic allow;
  logic lock_byte_write;
  logic go;

  // a page is locked when its bit in the lock byte is zero
  function automatic logic page_locked(input logic [AW-1:0] a,
                                       input logic [7:0] lb);
    logic [PW-1:0] pg;
    pg = a[AW-1 -: PW];
    page_locked = !lb[pg];
  endfunction : page_locked

  function automatic logic in_reserved(input logic [AW-1:0] a);
    in_reserved = (a >= flash_guard_pkg::RESERVED_BASE);
  endfunction : in_reserved

  assign we_en = psc_q[flash_guard_pkg::PSC_WE_BIT];
  assign ee_en = psc_q[flash_guard_pkg::PSC_EE_BIT];

  // writes become page erases when both enables are set
  always_comb begin
    eff_op = REQ_BUS.op;
    if (REQ_BUS.op == flash_guard_pkg::OP_WRITE && we_en && ee_en) begin
      eff_op = flash_guard_pkg::OP_ERASE;
    end
  end

  always_comb begin
    ctx.exec_locked = page_locked(REQ_BUS.pc, LOCK_BYTE);
    ctx.target_locked = page_locked(REQ_BUS.addr, LOCK_BYTE);
    ctx.target_lock_page =
      REQ_BUS.addr[AW-1 -: PW] == flash_guard_pkg::LOCK_PAGE;
    ctx.target_reserved = in_reserved(REQ_BUS.addr);
    ctx.target_lock_byte = REQ_BUS.addr == flash_guard_pkg::LOCK_BYTE_ADDR;
  end

  flash_access_rules u_rules (
    .CTX(ctx),
    .OP(eff_op),
    .ALLOW(allow)
  );

  // lock byte can only be programmed from erased; any change is refused
  assign lock_byte_write = ctx.target_lock_byte &&
    eff_op == flash_guard_pkg::OP_WRITE &&
    LOCK_BYTE != flash_guard_pkg::ERASED_BYTE;

  assign go = REQ && allow && !lock_byte_write;

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      psc_q <= flash_guard_pkg::PSC_RESET;
    end else if (SFR_WE && SFR_ADDR == flash_guard_pkg::PSC_OFFSET) begin
      psc_q <= {6'h00, SFR_WDATA[1:0]};
    end
  end

  always_comb begin
    SFR_RDATA = 8'h00;
    if (SFR_ADDR == flash_guard_pkg::PSC_OFFSET) begin
      SFR_RDATA = psc_q;
    end
  end
  assign PSC_STATE = psc_q;

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      FL_READ <= 1'b0;
      FL_WRITE <= 1'b0;
      FL_ERASE <= 1'b0;
      FL_ADDR <= '0;
      FL_WDATA <= 8'h00;
    end else begin
      FL_READ <= go && eff_op == flash_guard_pkg::OP_READ;
      // writes without the enable never reach the array
      FL_WRITE <= go && eff_op == flash_guard_pkg::OP_WRITE
                  && we_en;
      FL_ERASE <= go && eff_op == flash_guard_pkg::OP_ERASE
                  && (REQ_BUS.op != flash_guard_pkg::OP_WRITE
                      || we_en);
      FL_ADDR <= REQ_BUS.addr;
      FL_WDATA <= REQ_BUS.wdata;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      FLASH_ERR_RST <= 1'b0;
    end else begin
      FLASH_ERR_RST <= REQ && (!allow || lock_byte_write);
    end
  end

  property p_err_no_access;
    @(posedge CLK_SYS) disable iff (!RST_N)
      FLASH_ERR_RST |-> !(FL_READ || FL_WRITE || FL_ERASE);
  endproperty
  a_err_no_access: assert property (p_err_no_access)
    else $error("flash access completed despite error reset");

  property p_reserved;
    @(posedge CLK_SYS) disable iff (!RST_N)
      REQ && in_reserved(REQ_BUS.addr) |=> FLASH_ERR_RST;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved access did not raise error reset");

  property p_lock_page_erase;
    @(posedge CLK_SYS) disable iff (!RST_N)
      REQ && ctx.target_lock_page && eff_op == flash_guard_pkg::OP_ERASE
      |=> FLASH_ERR_RST && !FL_ERASE;
  endproperty
  a_lock_page_erase: assert property (p_lock_page_erase)
    else $error("lock byte page erase not refused");

  property p_lockbyte_read;
    @(posedge CLK_SYS) disable iff (!RST_N)
      REQ && ctx.target_lock_byte && REQ_BUS.op == flash_guard_pkg::OP_READ
      |=> FL_READ;
  endproperty
  a_lockbyte_read: assert property (p_lockbyte_read)
    else $error("lock byte read refused");

  property p_unlocked_ok;
    @(posedge CLK_SYS) disable iff (!RST_N)
      REQ && !ctx.target_locked && !ctx.target_lock_page
      && !ctx.target_reserved |=> !FLASH_ERR_RST;
  endproperty
  a_unlocked_ok: assert property (p_unlocked_ok)
    else $error("unlocked page access refused");

  property p_locked_from_unlocked;
    @(posedge CLK_SYS) disable iff (!RST_N)
      REQ && ctx.target_locked && !ctx.exec_locked
      && !(ctx.target_lock_byte && eff_op == flash_guard_pkg::OP_READ)
      |=> FLASH_ERR_RST;
  endproperty
  a_locked_from_unlocked: assert property (p_locked_from_unlocked)
    else $error("locked page reached from unlocked code");

  property p_locked_from_locked;
    @(posedge CLK_SYS) disable iff (!RST_N)
      REQ && ctx.target_locked && ctx.exec_locked && !ctx.target_lock_page
      && !ctx.target_reserved |=> !FLASH_ERR_RST;
  endproperty
  a_locked_from_locked: assert property (p_locked_from_locked)
    else $error("locked code refused a locked page");

  property p_lockpage_rw_locked;
    @(posedge CLK_SYS) disable iff (!RST_N)
      REQ && ctx.target_lock_page && ctx.exec_locked && !lock_byte_write
      && eff_op != flash_guard_pkg::OP_ERASE |=> !FLASH_ERR_RST;
  endproperty
  a_lockpage_rw_locked: assert property (p_lockpage_rw_locked)
    else $error("locked code refused lock page read or write");

  property p_lockpage_unl;
    @(posedge CLK_SYS) disable iff (!RST_N)
      REQ && ctx.target_lock_page && !ctx.exec_locked && ctx.target_locked
      && !ctx.target_lock_byte |=> FLASH_ERR_RST;
  endproperty
  a_lockpage_unl: assert property (p_lockpage_unl)
    else $error("locked lock page reached from unlocked code");

  property p_lockbyte_change;
    @(posedge CLK_SYS) disable iff (!RST_N)
      REQ && lock_byte_write |=> FLASH_ERR_RST && !FL_WRITE;
  endproperty
  a_lockbyte_change: assert property (p_lockbyte_change)
    else $error("lock byte rewritten");

  property p_write_gate;
    @(posedge CLK_SYS) disable iff (!RST_N)
      FL_WRITE |-> $past(we_en) && !$past(ee_en);
  endproperty
  a_write_gate: assert property (p_write_gate)
    else $error("flash write without write enable");

  property p_erase_by_write;
    @(posedge CLK_SYS) disable iff (!RST_N)
      REQ && go && REQ_BUS.op == flash_guard_pkg::OP_WRITE && we_en && ee_en
      |=> FL_ERASE && !FL_WRITE;
  endproperty
  a_erase_by_write: assert property (p_erase_by_write)
    else $error("write with erase enable did not erase page");
endmodule : flash_lock_access_guard

// file: flash_guard_pkg.sv
// Purpose: shared constants and types for the flash access guard
// Assumes: 2 KB program flash split into 512-byte pages
// Notes: the lock byte is the last byte of page 2, just below the reserved area
package flash_guard_pkg;
  localparam int ADDR_W = 11;
  localparam int PAGE_W = 2;
  localparam logic [7:0] PSC_OFFSET = 8'h8F;
  localparam logic [7:0] PSC_RESET = 8'h00;
  localparam int PSC_WE_BIT = 0;
  localparam int PSC_EE_BIT = 1;
  localparam logic [ADDR_W-1:0] LOCK_BYTE_ADDR = 11'h5FF;
  localparam logic [ADDR_W-1:0] RESERVED_BASE = 11'h600;
  localparam logic [PAGE_W-1:0] LOCK_PAGE = 2'h2;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;

  typedef enum logic [1:0] {OP_READ, OP_WRITE, OP_ERASE} op_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [ADDR_W-1:0] pc;
    op_t op;
    logic [7:0] wdata;
  } flash_req_t;

  typedef struct packed {
    logic exec_locked;
    logic target_locked;
    logic target_lock_page;
    logic target_reserved;
    logic target_lock_byte;
  } access_ctx_t;
endpackage : flash_guard_pkg

// file: flash_access_rules.sv
// Purpose: combinational verdict on one flash access
// Assumes: context flags already decoded by the caller
// Notes: pure logic, no state
`timescale 1ns/1ns
module flash_access_rules (
  input wire flash_guard_pkg::access_ctx_t CTX,
  input wire flash_guard_pkg::op_t OP,
  output logic ALLOW
);
  always_comb begin
    ALLOW = 1'b0;
    if (CTX.target_reserved) begin
      ALLOW = 1'b0;
    end else if (CTX.target_lock_byte && OP == flash_guard_pkg::OP_READ) begin
      ALLOW = 1'b1;
    end else if (CTX.target_lock_page) begin
      if (OP == flash_guard_pkg::OP_ERASE) begin
        ALLOW = 1'b0;
      end else if (CTX.exec_locked) begin
        ALLOW = 1'b1;
      end else begin
        ALLOW = !CTX.target_locked;
      end
    end else if (!CTX.target_locked) begin
      ALLOW = 1'b1;
    end else begin
      ALLOW = CTX.exec_locked;
    end
  end
endmodule : flash_access_rules

// file: core_model.sv
// Purpose: processor core model issuing flash accesses to the guard
// Assumes: one access per cycle, driven just after the falling edge
// Notes: bus is inverted while idle so a stale value cannot pass
`timescale 1ns/1ns
module core_model (
  input wire logic clk,
  output logic req,
  output flash_guard_pkg::flash_req_t req_bus
);
  initial begin
    req = 1'b0;
    req_bus = '0;
  end

  task automatic drive(input logic [10:0] a, input flash_guard_pkg::op_t op);
    @(negedge clk);
    req = 1'b1;
    req_bus = '{addr: a, pc: 11'h010, op: op, wdata: 8'h5A};
  endtask : drive

  task automatic stop();
    @(negedge clk);
    req = 1'b0;
    req_bus = ~req_bus;
  endtask : stop
endmodule : core_model

// file: testbench.sv
// Purpose: self-checking bench for the flash access guard
// Assumes: code runs from page 0, so lock byte bit 0 sets the exec state
// Notes: expected flags are {error, erase, write, read}
`timescale 1ns/1ns
module testbench;
  typedef struct packed {
    logic [7:0] lb;
    logic [1:0] psc;
    logic [10:0] addr;
    flash_guard_pkg::op_t op;
    logic [3:0] exp;
  } row_t;
  localparam flash_guard_pkg::op_t RD = flash_guard_pkg::OP_READ;
  localparam flash_guard_pkg::op_t WR = flash_guard_pkg::OP_WRITE;
  localparam flash_guard_pkg::op_t ER = flash_guard_pkg::OP_ERASE;
  row_t rows[21] = '{
    '{8'hFF, 2'h0, 11'h210, RD, 4'h1},
    '{8'hFE, 2'h0, 11'h210, RD, 4'h1},
    '{8'hFF, 2'h1, 11'h210, WR, 4'h2},
    '{8'hFF, 2'h0, 11'h210, WR, 4'h0},
    '{8'hFF, 2'h3, 11'h210, WR, 4'h4},
    '{8'hFF, 2'h0, 11'h210, ER, 4'h4},
    '{8'hFD, 2'h0, 11'h210, RD, 4'h8},
    '{8'hFD, 2'h1, 11'h210, ER, 4'h8},
    '{8'hFC, 2'h1, 11'h210, WR, 4'h2},
    '{8'hFF, 2'h0, 11'h400, ER, 4'h8},
    '{8'hFC, 2'h0, 11'h400, ER, 4'h8},
    '{8'hFB, 2'h1, 11'h400, WR, 4'h8},
    '{8'hFF, 2'h1, 11'h401, WR, 4'h2},
    '{8'hFA, 2'h0, 11'h400, RD, 4'h1},
    '{8'hFA, 2'h1, 11'h401, WR, 4'h2},
    '{8'hFB, 2'h0, 11'h5FF, RD, 4'h1},
    '{8'hFE, 2'h1, 11'h5FF, WR, 4'h8},
    '{8'hFF, 2'h1, 11'h5FF, WR, 4'h2},
    '{8'hFF, 2'h0, 11'h600, RD, 4'h8},
    '{8'hFE, 2'h1, 11'h7FF, WR, 4'h8},
    '{8'hFF, 2'h3, 11'h400, WR, 4'h8}
  };
  logic clk_sys, rst_n, sfr_we, req;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, lock_byte, psc_state;
  logic [7:0] fl_wdata;
  logic fl_read, fl_write, fl_erase, err_rst;
  logic [10:0] fl_addr;
  flash_guard_pkg::flash_req_t req_bus;
  int failures = 0;
  int n_tests = 0;

  flash_lock_access_guard u_flash_lock_access_guard (.CLK_SYS(clk_sys),
    .RST_N(rst_n), .SFR_WE(sfr_we), .SFR_ADDR(sfr_addr),
    .SFR_WDATA(sfr_wdata), .SFR_RDATA(sfr_rdata), .REQ(req),
    .REQ_BUS(req_bus), .LOCK_BYTE(lock_byte), .FL_READ(fl_read),
    .FL_WRITE(fl_write), .FL_ERASE(fl_erase), .FL_ADDR(fl_addr),
    .FL_WDATA(fl_wdata), .FLASH_ERR_RST(err_rst), .PSC_STATE(psc_state));
  core_model u_core_model (.clk(clk_sys), .req(req), .req_bus(req_bus));

  task automatic complete_run();
    if (failures == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : complete_run

  task automatic chk_flags(input logic [3:0] exp);
    n_tests++;
    if ({err_rst, fl_erase, fl_write, fl_read} !== exp) begin
      failures++;
      $display("BAD %0t flags want %h", $time, exp);
    end
  endtask : chk_flags

  task automatic chk_val(input logic [10:0] got, input logic [10:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t value %h want %h", $time, got, exp);
    end
  endtask : chk_val

  task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    sfr_we = 1'b1;
    sfr_addr = a;
    sfr_wdata = d;
    @(negedge clk_sys);
    sfr_we = 1'b0;
    sfr_addr = 8'h8F;
  endtask : sfr_wr

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  // about 110 cycles are needed; the limit of 2000 cycles leaves a wide margin
  initial begin
    #200000;
    failures++;
    complete_run();
  end

  initial begin
    rst_n = 1'b0;
    sfr_we = 1'b0;
    sfr_addr = 8'h8F;
    sfr_wdata = 8'h00;
    lock_byte = 8'hFF;
    repeat (5) @(negedge clk_sys);
    rst_n = 1'b1;
    #1;
    chk_val({3'h0, psc_state}, 11'h000);
    chk_val({3'h0, sfr_rdata}, 11'h000);
    chk_flags(4'h0);
    foreach (rows[i]) begin
      lock_byte = rows[i].lb;
      sfr_wr(8'h8F, {6'h00, rows[i].psc});
      u_core_model.drive(rows[i].addr, rows[i].op);
      u_core_model.stop();
      chk_flags(rows[i].exp);
      if (rows[i].exp[1:0] != 2'h0) chk_val(fl_addr, rows[i].addr);
      chk_val({3'h0, fl_wdata}, 11'h05A);
    end
    // back to back: the second access must not mask the first
    lock_byte = 8'hFD;
    u_core_model.drive(11'h000, RD);
    u_core_model.drive(11'h3FF, RD);
    chk_flags(4'h1);
    u_core_model.stop();
    chk_flags(4'h8);
    lock_byte = 8'hFF;
    sfr_wr(8'h8F, 8'h00);
    sfr_wr(8'h90, 8'h03);
    chk_val({3'h0, psc_state}, 11'h000);
    u_core_model.drive(11'h210, WR);
    u_core_model.stop();
    chk_flags(4'h0);
    sfr_addr = 8'h90;
    #1;
    chk_val({3'h0, sfr_rdata}, 11'h000);
    sfr_wr(8'h8F, 8'h03);
    #1;
    chk_val({3'h0, sfr_rdata}, 11'h003);
    // reset lands on a pending erase-by-write; nothing may reach flash
    u_core_model.drive(11'h210, WR);
    rst_n = 1'b0;
    u_core_model.stop();
    chk_flags(4'h0);
    chk_val({3'h0, psc_state}, 11'h000);
    rst_n = 1'b1;
    // outputs stay quiet after release and the guard works again
    repeat (2) @(negedge clk_sys);
    chk_flags(4'h0);
    chk_val({3'h0, psc_state}, 11'h000);
    u_core_model.drive(11'h210, RD);
    u_core_model.stop();
    chk_flags(4'h1);
    complete_run();
  end
endmodule : testbench
